//--- src/msc_top.sv
// Sideband control of a pluggable module: select, reset, low power, presence, interrupt, 2-wire.
`timescale 1ns/1ps
module msc_top
   import msc_pkg::*;
#(
   parameter int MAP_DEPTH = 16
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic MODULE_SELECT_N,
   input wire logic MODULE_RESET_N,
   input wire logic LOW_POWER_SELECT,
   input wire logic SCL,
   input wire logic SDA_I,
   input wire logic [FLAG_W-2:0] FAULT_EVENT,
   output logic SDA_O,
   output logic SDA_OE_N,
   output logic INTERRUPT_N_O,
   output logic INTERRUPT_N_OE_N,
   output logic MODULE_PRESENT_N,
   output logic HIGH_POWER_EN,
   output logic CONFIG_PENDING
);
   localparam int AW = (MAP_DEPTH > 1) ? $clog2(MAP_DEPTH) : 1;

   function automatic logic in_map(input logic [7:0] p);
      return 32'(p) < MAP_DEPTH;
   endfunction : in_map

   // Core clock domain.
   logic [1:0] rst_pin_ff;
   logic [1:0] lp_ff;
   logic [2:0] rd_sync_ff;
   msc_ctl_t ctl_ff, nxt_ctl;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt, low_ff, nxt_low;
   logic [FLAG_W-1:0] flags_ff, nxt_flags;
   logic map_rst_ff, nxt_map_rst;
   logic pend_ff, nxt_pend;
   logic int_oe_n_ff, nxt_int_oe_n;
   logic hp_ff, nxt_hp;
   logic rst_low, qual, rd_ev;

   // Link clock domain.
   logic [1:0] sel_ff, ce_scl_ff, pend_scl_ff;
   logic [FLAG_W-1:0] flags_meta_ff, flags_scl_ff;
   logic start_tgl_ff;
   msc_bus_t bus_ff, nxt_bus;
   logic [3:0] bit_ff, nxt_bit;
   logic [7:0] shift_ff, nxt_shift, ptr_ff, nxt_ptr, byte_in, rd_data;
   logic first_ff, nxt_first, rw_ff, nxt_rw, seen_ff, nxt_seen, rd_tgl_ff, nxt_rd_tgl;
   logic [7:0] map_ff [MAP_DEPTH];
   logic [7:0] nxt_map [MAP_DEPTH];
   logic sda_oe_n_ff, nxt_sda_oe_n;
   logic sel, load_rd;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rst_pin_ff <= 2'h3;
         lp_ff <= 2'h3;
         rd_sync_ff <= 3'h0;
      end else if (CE) begin
         rst_pin_ff <= {rst_pin_ff[0], MODULE_RESET_N};
         lp_ff <= {lp_ff[0], LOW_POWER_SELECT};
         rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
      end
   end

   assign rst_low = !rst_pin_ff[1];
   assign rd_ev = rd_sync_ff[1] ^ rd_sync_ff[2];
   assign qual = rst_low && (low_ff == CNT_W'(RESET_MIN_CYC));

   always_comb begin
      nxt_ctl = ctl_ff;
      nxt_cnt = cnt_ff;
      nxt_low = low_ff;
      nxt_flags = flags_ff;
      nxt_map_rst = map_rst_ff;
      nxt_pend = pend_ff;
      nxt_int_oe_n = int_oe_n_ff;
      nxt_hp = hp_ff;
      if (CE) begin
         if (!rst_low) begin
            nxt_low = '0;
         end else if (!qual) begin
            nxt_low = low_ff + 1'b1;
         end
         if (qual) begin
            nxt_ctl = CTL_HOLD;
            nxt_map_rst = 1'b1;
            nxt_pend = 1'b1;
            nxt_flags = '0;
         end else begin
            case (ctl_ff)
               CTL_HOLD: begin
                  if (!rst_low) begin
                     nxt_ctl = CTL_INIT;
                     nxt_cnt = '0;
                  end
               end
               CTL_INIT: begin
                  nxt_cnt = cnt_ff + 1'b1;
                  if (cnt_ff == CNT_W'(INIT_CYC - 1)) begin
                     nxt_ctl = CTL_READY;
                     nxt_pend = 1'b0;
                     nxt_map_rst = 1'b0;
                     nxt_flags[DONE_BIT] = 1'b1;
                  end
               end
               CTL_READY: begin
                  nxt_flags = (rd_ev ? '0 : flags_ff) | {FAULT_EVENT, 1'b0};
               end
               default: begin
                  nxt_ctl = CTL_INIT;
                  nxt_cnt = '0;
               end
            endcase
         end
         nxt_int_oe_n = !((nxt_ctl == CTL_READY) && (|nxt_flags));
         nxt_hp = (nxt_ctl == CTL_READY) && !lp_ff[1];
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctl_ff <= CTL_INIT;
         cnt_ff <= '0;
         low_ff <= '0;
         flags_ff <= '0;
         map_rst_ff <= 1'b1;
         pend_ff <= 1'b1;
         int_oe_n_ff <= 1'b1;
         hp_ff <= 1'b0;
         INTERRUPT_N_O <= 1'b0;
         MODULE_PRESENT_N <= 1'b0;
      end else begin
         ctl_ff <= nxt_ctl;
         cnt_ff <= nxt_cnt;
         low_ff <= nxt_low;
         flags_ff <= nxt_flags;
         map_rst_ff <= nxt_map_rst;
         pend_ff <= nxt_pend;
         int_oe_n_ff <= nxt_int_oe_n;
         hp_ff <= nxt_hp;
         INTERRUPT_N_O <= 1'b0;
         MODULE_PRESENT_N <= 1'b0;
      end
   end

   assign INTERRUPT_N_OE_N = int_oe_n_ff;
   assign HIGH_POWER_EN = hp_ff;
   assign CONFIG_PENDING = pend_ff;

   // The map reset asserts asynchronously; it releases while the host waits for the
   // completion interrupt, so the bus is idle then and no synchroniser is needed.
   always_ff @(posedge SCL or posedge map_rst_ff) begin
      if (map_rst_ff) begin
         sel_ff <= 2'h3;
         // Starts enabled, so the first frame after release keeps its leading bits.
         ce_scl_ff <= 2'h3;
         pend_scl_ff <= 2'h3;
         flags_meta_ff <= '0;
         flags_scl_ff <= '0;
      end else begin
         sel_ff <= {sel_ff[0], MODULE_SELECT_N};
         ce_scl_ff <= {ce_scl_ff[0], CE};
         pend_scl_ff <= {pend_scl_ff[0], pend_ff};
         flags_meta_ff <= flags_ff;
         flags_scl_ff <= flags_meta_ff;
      end
   end

   // A start is a falling data line while the clock is high; only a data edge shows it.
   always_ff @(negedge SDA_I or posedge map_rst_ff) begin
      if (map_rst_ff) begin
         start_tgl_ff <= 1'b0;
      end else if (SCL) begin
         start_tgl_ff <= ~start_tgl_ff;
      end
   end

   assign sel = !sel_ff[1];
   assign byte_in = {shift_ff[6:0], SDA_I};

   always_comb begin
      rd_data = 8'h00;
      if (ptr_ff == STATUS_OFS) begin
         rd_data[PEND_BIT] = pend_scl_ff[1];
      end else if (ptr_ff == FLAG_OFS) begin
         rd_data = flags_scl_ff;
      end else if (in_map(ptr_ff)) begin
         rd_data = map_ff[ptr_ff[AW-1:0]];
      end
   end

   always_comb begin
      nxt_bus = bus_ff;
      nxt_bit = bit_ff;
      nxt_shift = shift_ff;
      nxt_ptr = ptr_ff;
      nxt_first = first_ff;
      nxt_rw = rw_ff;
      nxt_seen = seen_ff;
      nxt_rd_tgl = rd_tgl_ff;
      nxt_map = map_ff;
      load_rd = 1'b0;
      if (ce_scl_ff[1]) begin
         if (start_tgl_ff != seen_ff) begin
            nxt_seen = start_tgl_ff;
            nxt_bus = BUS_ADDR;
            nxt_shift = {7'h00, SDA_I};
            nxt_bit = 4'h1;
         end else begin
            case (bus_ff)
               BUS_ADDR: begin
                  nxt_shift = byte_in;
                  nxt_bit = bit_ff + 1'b1;
                  if (bit_ff == LAST_BIT) begin
                     nxt_rw = byte_in[0];
                     nxt_bus = (sel && byte_in[7:1] == DEV_ADDR) ? BUS_ACK_A : BUS_IDLE;
                  end
               end
               BUS_ACK_A: begin
                  nxt_bit = 4'h0;
                  nxt_first = 1'b1;
                  load_rd = sel && rw_ff;
                  nxt_bus = !sel ? BUS_IDLE : (rw_ff ? BUS_RD : BUS_WR);
               end
               BUS_WR: begin
                  nxt_shift = byte_in;
                  nxt_bit = bit_ff + 1'b1;
                  if (bit_ff == LAST_BIT) begin
                     nxt_bus = sel ? BUS_ACK_W : BUS_IDLE;
                     nxt_first = 1'b0;
                     if (first_ff) begin
                        nxt_ptr = byte_in;
                     end else begin
                        if (in_map(ptr_ff) && ptr_ff != STATUS_OFS && ptr_ff != FLAG_OFS) begin
                           nxt_map[ptr_ff[AW-1:0]] = byte_in;
                        end
                        nxt_ptr = ptr_ff + 1'b1;
                     end
                  end
               end
               BUS_ACK_W: begin
                  nxt_bit = 4'h0;
                  nxt_bus = sel ? BUS_WR : BUS_IDLE;
               end
               BUS_RD: begin
                  nxt_shift = {shift_ff[6:0], 1'b0};
                  nxt_bit = bit_ff + 1'b1;
                  if (!sel) begin
                     nxt_bus = BUS_IDLE;
                  end else if (bit_ff == LAST_BIT) begin
                     nxt_bus = BUS_ACK_R;
                  end
               end
               BUS_ACK_R: begin
                  nxt_bit = 4'h0;
                  load_rd = sel && !SDA_I;
                  nxt_bus = load_rd ? BUS_RD : BUS_IDLE;
               end
               default: begin
                  nxt_bus = BUS_IDLE;
               end
            endcase
            if (load_rd) begin
               nxt_shift = rd_data;
               nxt_ptr = ptr_ff + 1'b1;
               nxt_rd_tgl = rd_tgl_ff ^ (ptr_ff == FLAG_OFS);
            end
         end
      end
   end

   always_ff @(posedge SCL or posedge map_rst_ff) begin
      if (map_rst_ff) begin
         bus_ff <= BUS_IDLE;
         bit_ff <= 4'h0;
         shift_ff <= 8'h00;
         ptr_ff <= 8'h00;
         first_ff <= 1'b0;
         rw_ff <= 1'b0;
         seen_ff <= 1'b0;
         rd_tgl_ff <= 1'b0;
         for (int i = 0; i < MAP_DEPTH; i++) begin
            map_ff[i] <= MAP_RESET_VAL;
         end
      end else begin
         bus_ff <= nxt_bus;
         bit_ff <= nxt_bit;
         shift_ff <= nxt_shift;
         ptr_ff <= nxt_ptr;
         first_ff <= nxt_first;
         rw_ff <= nxt_rw;
         seen_ff <= nxt_seen;
         rd_tgl_ff <= nxt_rd_tgl;
         map_ff <= nxt_map;
      end
   end

   // Data changes only on the falling clock so it is stable for the host's rising sample.
   always_comb begin
      nxt_sda_oe_n = sda_oe_n_ff;
      if (ce_scl_ff[1]) begin
         case (bus_ff)
            BUS_ACK_A: nxt_sda_oe_n = 1'b0;
            BUS_ACK_W: nxt_sda_oe_n = 1'b0;
            BUS_RD: nxt_sda_oe_n = shift_ff[7];
            default: nxt_sda_oe_n = 1'b1;
         endcase
      end
   end

   always_ff @(negedge SCL or posedge map_rst_ff) begin
      if (map_rst_ff) begin
         sda_oe_n_ff <= 1'b1;
         SDA_O <= 1'b0;
      end else begin
         sda_oe_n_ff <= nxt_sda_oe_n;
         SDA_O <= 1'b0;
      end
   end

   assign SDA_OE_N = sda_oe_n_ff;
endmodule : msc_top

//--- src/msc_pkg.sv
// Shared constants and types for the module sideband control block.
package msc_pkg;
   localparam int CLK_MHZ = 200;
   localparam int RESET_MIN_NS = 2000;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int INIT_NS = 1000;
   localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 16;
   localparam int FLAG_W = 8;
   localparam int PEND_BIT = 0;
   localparam int DONE_BIT = 0;
   localparam logic [7:0] STATUS_OFS = 8'h02;
   localparam logic [7:0] FLAG_OFS = 8'h03;
   localparam logic [7:0] MAP_RESET_VAL = 8'h00;
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [3:0] LAST_BIT = 4'h7;

   typedef enum logic [2:0] {
      CTL_INIT = 3'b001,
      CTL_HOLD = 3'b010,
      CTL_READY = 3'b100
   } msc_ctl_t;

   typedef enum logic [6:0] {
      BUS_IDLE = 7'b000_0001,
      BUS_ADDR = 7'b000_0010,
      BUS_ACK_A = 7'b000_0100,
      BUS_WR = 7'b000_1000,
      BUS_ACK_W = 7'b001_0000,
      BUS_RD = 7'b010_0000,
      BUS_ACK_R = 7'b100_0000
   } msc_bus_t;
endpackage : msc_pkg

//--- verification/msc_top_asserts.sv
// Concurrent checks on the sideband control pins.
`timescale 1ns/1ps
module msc_top_asserts
   import msc_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST,
   input wire logic MODULE_SELECT_N,
   input wire logic MODULE_RESET_N,
   input wire logic LOW_POWER_SELECT,
   input wire logic SCL,
   input wire logic [FLAG_W-2:0] FAULT_EVENT,
   input wire logic SDA_OE_N,
   input wire logic INTERRUPT_N_O,
   input wire logic INTERRUPT_N_OE_N,
   input wire logic MODULE_PRESENT_N,
   input wire logic HIGH_POWER_EN,
   input wire logic CONFIG_PENDING
);
   logic [CNT_W-1:0] low_ff;
   logic [CNT_W-1:0] nxt_low;
   // Saturates, so a very long hold never wraps back under the limit.
   always_comb begin
      nxt_low = (MODULE_RESET_N || (&low_ff)) ? low_ff & {CNT_W{!MODULE_RESET_N}} : low_ff + 1'b1;
   end
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         low_ff <= '0;
      end else begin
         low_ff <= nxt_low;
      end
   end
   sel_gate_a: assert property (@(posedge SCL) disable iff (RST)
      MODULE_SELECT_N [*4] |-> SDA_OE_N) else $error("select high but bus driven");
   hold_pend_a: assert property (@(posedge MCLK) disable iff (RST)
      low_ff > RESET_MIN_CYC + 4 |-> CONFIG_PENDING) else $error("long reset not held");
   done_int_a: assert property (@(posedge MCLK) disable iff (RST)
      $fell(CONFIG_PENDING) |-> !INTERRUPT_N_OE_N) else $error("no completion interrupt");
   low_power_a: assert property (@(posedge MCLK) disable iff (RST)
      LOW_POWER_SELECT [*5] |-> !HIGH_POWER_EN) else $error("full power in low power");
   present_tied_a: assert property (@(posedge MCLK) disable iff (RST)
      !MODULE_PRESENT_N) else $error("present line not low");
   fault_int_a: assert property (@(posedge MCLK) disable iff (RST)
      (|FAULT_EVENT) && !CONFIG_PENDING |-> ##[1:3] !INTERRUPT_N_OE_N && !INTERRUPT_N_O)
      else $error("fault not flagged");
   sda_edge_a: assert property (@(posedge MCLK) disable iff (RST)
      !$stable(SDA_OE_N) |-> !SCL) else $error("data moved while clock high");
   pend_quiet_a: assert property (@(posedge MCLK) disable iff (RST)
      CONFIG_PENDING |-> INTERRUPT_N_OE_N) else $error("interrupt during reset");
endmodule : msc_top_asserts
bind msc_top msc_top_asserts i_msc_top_asserts (.*);

//--- verification/msc_host.sv
// Host board controller model on the 2-wire bus and select pin.
`timescale 1ns/1ps
module msc_host (
   output logic scl,
   output logic sel_n,
   output wire logic sda,
   input wire logic dev_oe_n,
   input wire logic dev_lvl
);
   logic hd;
   // Pull-up wire: a released line reads high, any low driver wins.
   assign sda = hd & (dev_oe_n | dev_lvl);
   initial begin
      scl = 1'b1;
      sel_n = 1'b0;
      hd = 1'b1;
   end
   task automatic pick(input logic v);
      sel_n = v;
   endtask : pick
   task automatic start();
      hd = 1'b1;
      #40 scl = 1'b1;
      #40 hd = 1'b0;
      #40 scl = 1'b0;
      #40;
   endtask : start
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
      output logic ak);
      logic [8:0] b;
      b = {tx, mack};
      for (int i = 8; i >= 0; i--) begin
         hd = b[i];
         #40 scl = 1'b1;
         b[i] = sda;
         #80 scl = 1'b0;
         #40;
      end
      rx = b[8:1];
      ak = b[0];
   endtask : xfer
   task automatic acc(input logic [7:0] ad, input logic rd, input logic [7:0] o,
      input logic [7:0] d, output logic [7:0] q, output logic ak);
      logic a;
      start();
      xfer(ad, 1'b1, q, ak);
      xfer(o, 1'b1, q, a);
      if (rd) begin
         start();
         xfer(ad | 8'h01, 1'b1, q, a);
      end
      xfer(rd ? 8'hFF : d, 1'b1, q, a);
      hd = 1'b0;
      #40 scl = 1'b1;
      #40 hd = 1'b1;
      #40;
   endtask : acc
endmodule : msc_host

//--- verification/tb_top.sv
// Self-checking bench for the sideband control block.
`timescale 1ns/1ps
module tb_top;
   import msc_pkg::*;
   localparam logic [7:0] WA = {DEV_ADDR, 1'b0};
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic rpin = 1'b1;
   logic lp = 1'b0;
   logic [FLAG_W-2:0] ev = '0;
   logic oe_n, lvl, io, ioe_n, prs_n, hpe, pend, scl, sel_n;
   wire sda;
   int err_total = 0;
   int checks = 0;
   logic [7:0] q;
   logic ak;
   msc_top i_msc_top (.MCLK(mclk), .RST(rst), .CE(1'b1), .MODULE_SELECT_N(sel_n),
      .MODULE_RESET_N(rpin), .LOW_POWER_SELECT(lp), .SCL(scl), .SDA_I(sda), .FAULT_EVENT(ev),
      .SDA_O(lvl), .SDA_OE_N(oe_n), .INTERRUPT_N_O(io), .INTERRUPT_N_OE_N(ioe_n),
      .MODULE_PRESENT_N(prs_n), .HIGH_POWER_EN(hpe), .CONFIG_PENDING(pend));
   msc_host i_msc_host (.scl(scl), .sel_n(sel_n), .sda(sda), .dev_oe_n(oe_n), .dev_lvl(lvl));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   task automatic wt(input bit on_int, input logic v);
      int n = 0;
      while (((on_int ? ioe_n : pend) !== v) && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n == 3000) begin
         err_total++;
         conclude();
      end
   endtask : wt
   task automatic rd(input logic [7:0] o);
      i_msc_host.acc(WA, 1'b1, o, 8'h00, q, ak);
   endtask : rd
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      i_msc_host.acc(WA, 1'b0, o, d, q, ak);
   endtask : wr
   task automatic t_power();
      wt(1'b0, 1'b0);
      chk("power int", 8'h00, ioe_n);
      chk("present", 8'h00, prs_n);
      rd(STATUS_OFS);
      chk("status", 8'h00, q);
      rd(FLAG_OFS);
      chk("flags", 8'h01, q);
      chk("int off", 8'h01, ioe_n);
   endtask : t_power
   task automatic t_map();
      wr(8'h05, 8'hA5);
      wr(8'h0F, 8'h3C);
      wr(STATUS_OFS, 8'hFF);
      wr(8'h10, 8'h77);
      rd(8'h05);
      chk("map 5", 8'hA5, q);
      rd(8'h0F);
      chk("map 15", 8'h3C, q);
      rd(STATUS_OFS);
      chk("ro status", 8'h00, q);
      rd(8'h00);
      chk("map range", 8'h00, q);
   endtask : t_map
   task automatic t_select();
      i_msc_host.pick(1'b1);
      wr(8'h05, 8'h11);
      chk("ack unselected", 8'h01, ak);
      i_msc_host.pick(1'b0);
      i_msc_host.acc({DEV_ADDR + 7'h01, 1'b0}, 1'b0, 8'h05, 8'h22, q, ak);
      chk("ack other addr", 8'h01, ak);
      rd(8'h05);
      chk("map kept", 8'hA5, q);
   endtask : t_select
   task automatic t_fault();
      @(posedge mclk);
      ev <= 7'h04;
      @(posedge mclk);
      ev <= 7'h00;
      wt(1'b1, 1'b0);
      chk("fault int", 8'h00, ioe_n);
      rd(FLAG_OFS);
      chk("fault flags", 8'h08, q);
      chk("fault cleared", 8'h01, ioe_n);
   endtask : t_fault
   task automatic t_lp();
      @(posedge mclk);
      lp <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      chk("low power", 8'h00, hpe);
      @(posedge mclk);
      lp <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk("full power", 8'h01, hpe);
   endtask : t_lp
   task automatic t_reset();
      @(posedge mclk);
      rpin <= 1'b0;
      repeat (RESET_MIN_CYC / 2) @(posedge mclk);
      rpin <= 1'b1;
      repeat (8) @(posedge mclk);
      #1;
      chk("short pulse", 8'h00, pend);
      @(posedge mclk);
      rpin <= 1'b0;
      repeat (RESET_MIN_CYC + 10) @(posedge mclk);
      ev <= 7'h40;
      @(posedge mclk);
      ev <= 7'h00;
      repeat (4) @(posedge mclk);
      #1;
      chk("hold pend", 8'h01, pend);
      chk("hold int", 8'h01, ioe_n);
      @(posedge mclk);
      rpin <= 1'b1;
      wt(1'b0, 1'b0);
      chk("done int", 8'h00, ioe_n);
      rd(8'h05);
      chk("map default", MAP_RESET_VAL, q);
      rd(FLAG_OFS);
      chk("reset flags", 8'h01, q);
   endtask : t_reset
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_power();
      t_map();
      t_select();
      t_fault();
      t_lp();
      t_reset();
      conclude();
   end
endmodule : tb_top
